// ==== dplm_bridge_model.sv ====
// Purpose: behavioural power bridge feeding the monitor
// Assumes: bench sets the wanted bridge state each cycle
// Notes:   one register stage, as real sensing logic has
`timescale 1ns/1ps
`default_nettype none
module dplm_bridge_model (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   sys_rst,
    // bench control
    input  wire dplm_pkg::dplm_bridge_t want_i,
    // monitor side
    output var dplm_pkg::dplm_bridge_t  bridge_o
);
    dplm_pkg::dplm_bridge_t bridge_d;
    dplm_pkg::dplm_bridge_t bridge_q;
    // events stay one-cycle pulses, levels follow the bench
    always_comb begin
        bridge_d = want_i;
    end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bridge_q <= '0;
        end else begin
            bridge_q <= bridge_d;
        end
    end
    assign bridge_o = bridge_q;
endmodule
`default_nettype wire

// ==== dplm_monitor.sv ====
// Purpose: power limit supervisor with wishbone register file
// Assumes: bridge inputs come from logic on the same clock
// Notes:   ceiling math is linear between the two thresholds
`timescale 1ns/1ps
`default_nettype none

// How it works
// - while braking with recovery, dc link voltage is compared every cycle
// - lower threshold at index 0, upper threshold at index 1
// - above lower threshold, generator duty ceiling starts being reduced
// - ceiling falls linearly to zero at the upper threshold
// - over-voltage reduction sets cause bit 2 only in generator mode
// - over-current events counted; past allowance raise 0x2221 or 0x2222
// - current offset setting caps the braking current ceiling
// - cause bits stay set and accumulate until cleared
// - enable rising edge or a write to the cause offset clears the cause mask
// - bit 0 motor duty ceiling, bit 1 generator duty ceiling limiting
// - bit 3 when the current limiting controller acts
// - bit 4 positive, bit 5 negative motor current ceiling limiting
// - bit 6 positive, bit 7 negative generator current ceiling limiting
// - limit lamp output high while any limiting is active
// - active generator ceiling readable at its own offset
module dplm_monitor (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    // wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    output logic                       wb_err_o,
    // power bridge side
    input  wire dplm_pkg::dplm_bridge_t bridge_i,
    output logic      [15:0]           duty_out,
    output logic      [15:0]           braking_current_ceiling,
    output logic                       limit_lamp,
    output logic      [15:0]           fault_code,
    output logic                       fault_active
);

    // ---------------------------------------------
    // settings and state registers
    // ---------------------------------------------
    logic [15:0] brake_lo_q, brake_lo_d;
    logic [15:0] brake_hi_q, brake_hi_d;
    logic [15:0] duty_mot_q, duty_mot_d;
    logic [15:0] duty_gen_q, duty_gen_d;
    logic [15:0] cur_ofs_q,  cur_ofs_d;
    logic [15:0] oc_allow_q, oc_allow_d;
    logic [15:0] cause_q,    cause_d;
    logic [15:0] oc_cnt_q,   oc_cnt_d;
    logic [15:0] gen_act_q,  gen_act_d;
    logic [15:0] duty_q,     duty_d;
    logic [15:0] brk_ceil_q, brk_ceil_d;
    logic        lamp_q,     lamp_d;
    logic        en_prev_q,  en_prev_d;
    logic [31:0] rdat_q,     rdat_d;
    logic        ack_q,      ack_d;
    logic        err_q,      err_d;
    logic [15:0] fcode_q,    fcode_d;
    logic        fact_q,     fact_d;
    dplm_pkg::dplm_fault_state_t fst_q, fst_d;

    // ---------------------------------------------
    // combinational helpers
    // ---------------------------------------------
    logic        req;
    logic        wr;
    logic        hit;
    logic        en_rise;
    logic        ovolt;
    logic [15:0] span;
    logic [15:0] over;
    logic [31:0] prod;
    logic [15:0] scaled;
    logic [15:0] gen_ceil;
    logic [15:0] lim_set;
    logic        mot_duty_lim;
    logic        gen_duty_lim;

    assign req     = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    assign wr      = req && wb_we_i && hit;
    assign en_rise = bridge_i.drive_enable && !en_prev_q;

    // over-voltage ceiling scaling
    always_comb begin
        span     = brake_hi_q - brake_lo_q;
        over     = bridge_i.dc_link_mv - brake_lo_q;
        prod     = 32'h0000_0000;
        scaled   = duty_gen_q;
        ovolt    = 1'b0;
        gen_ceil = duty_gen_q;
        if (bridge_i.braking) begin
            if (bridge_i.dc_link_mv >= brake_hi_q) begin
                ovolt    = 1'b1;
                gen_ceil = 16'h0000;
            end else if (bridge_i.dc_link_mv > brake_lo_q) begin
                ovolt    = 1'b1;
                prod     = 32'(duty_gen_q) * 32'(span - over);
                scaled   = 16'((prod / {16'h0000, span}));
                gen_ceil = scaled;
            end
        end
    end

    // duty clamp and limiting causes
    always_comb begin
        mot_duty_lim = !bridge_i.gen_mode && (bridge_i.duty_cmd > duty_mot_q);
        gen_duty_lim = bridge_i.gen_mode && (bridge_i.duty_cmd > gen_ceil);
        lim_set = 16'h0000;
        lim_set[dplm_pkg::DPLM_BIT_MOT_DUTY] = mot_duty_lim;
        lim_set[dplm_pkg::DPLM_BIT_GEN_DUTY] = gen_duty_lim;
        lim_set[dplm_pkg::DPLM_BIT_OVERVOLT] = ovolt && bridge_i.gen_mode;
        lim_set[dplm_pkg::DPLM_BIT_CTRL_LIM] = bridge_i.ctrl_limiting;
        lim_set[dplm_pkg::DPLM_BIT_MOT_POS]  = bridge_i.mot_pos_lim;
        lim_set[dplm_pkg::DPLM_BIT_MOT_NEG]  = bridge_i.mot_neg_lim;
        lim_set[dplm_pkg::DPLM_BIT_GEN_POS]  = bridge_i.gen_pos_lim;
        lim_set[dplm_pkg::DPLM_BIT_GEN_NEG]  = bridge_i.gen_neg_lim;
        if (mot_duty_lim) begin
            duty_d = duty_mot_q;
        end else if (gen_duty_lim) begin
            duty_d = gen_ceil;
        end else begin
            duty_d = bridge_i.duty_cmd;
        end
        gen_act_d  = gen_ceil;
        brk_ceil_d = cur_ofs_q;
        lamp_d     = |lim_set;
        en_prev_d  = bridge_i.drive_enable;
        // set wins over clear: bits present this cycle survive
        if (en_rise || wr && (wb_adr_i == dplm_pkg::DPLM_OFS_CAUSE)) begin
            cause_d = lim_set;
        end else begin
            cause_d = cause_q | lim_set;
        end
    end

    // over-current counter and fault
    always_comb begin
        oc_cnt_d = oc_cnt_q;
        fst_d    = fst_q;
        if (en_rise) begin
            oc_cnt_d = 16'h0000;
            fst_d    = dplm_pkg::DPLM_RUN;
        end else begin
            case (fst_q)
                dplm_pkg::DPLM_RUN: begin
                    if (bridge_i.oc_pos_evt || bridge_i.oc_neg_evt) begin
                        if (oc_cnt_q >= oc_allow_q) begin
                            fst_d = bridge_i.oc_pos_evt ? dplm_pkg::DPLM_FAULT_P : dplm_pkg::DPLM_FAULT_N;
                        end else begin
                            oc_cnt_d = oc_cnt_q + 16'h0001;
                        end
                    end
                end
                default: begin
                    fst_d = fst_q;
                end
            endcase
        end
        // fault outputs registered from the next state
        fact_d = (fst_d != dplm_pkg::DPLM_RUN);
        if (fst_d == dplm_pkg::DPLM_FAULT_P) begin
            fcode_d = dplm_pkg::DPLM_FAULT_POS;
        end else if (fst_d == dplm_pkg::DPLM_FAULT_N) begin
            fcode_d = dplm_pkg::DPLM_FAULT_NEG;
        end else begin
            fcode_d = 16'h0000;
        end
    end

    // wishbone decode
    always_comb begin
        hit        = 1'b1;
        rdat_d     = 32'h0000_0000;
        brake_lo_d = brake_lo_q;
        brake_hi_d = brake_hi_q;
        duty_mot_d = duty_mot_q;
        duty_gen_d = duty_gen_q;
        cur_ofs_d  = cur_ofs_q;
        oc_allow_d = oc_allow_q;
        if (wb_adr_i == dplm_pkg::DPLM_OFS_BRAKE_LO) begin
            rdat_d[15:0] = brake_lo_q;
        end else if (wb_adr_i == dplm_pkg::DPLM_OFS_BRAKE_HI) begin
            rdat_d[15:0] = brake_hi_q;
        end else if (wb_adr_i == dplm_pkg::DPLM_OFS_DUTY_MOT) begin
            rdat_d[15:0] = duty_mot_q;
        end else if (wb_adr_i == dplm_pkg::DPLM_OFS_DUTY_GEN) begin
            rdat_d[15:0] = duty_gen_q;
        end else if (wb_adr_i == dplm_pkg::DPLM_OFS_DUTY_ACT) begin
            rdat_d[15:0] = gen_act_q;
        end else if (wb_adr_i == dplm_pkg::DPLM_OFS_CUR_OFS) begin
            rdat_d[15:0] = cur_ofs_q;
        end else if (wb_adr_i == dplm_pkg::DPLM_OFS_OC_ALLOW) begin
            rdat_d[15:0] = oc_allow_q;
        end else if (wb_adr_i == dplm_pkg::DPLM_OFS_CAUSE) begin
            rdat_d[15:0] = cause_q;
        end else if (wb_adr_i == dplm_pkg::DPLM_OFS_FAULT) begin
            rdat_d[15:0] = fault_code;
            rdat_d[16]   = fault_active;
        end else begin
            hit = 1'b0;
        end
        if (!req || wb_we_i) begin
            rdat_d = 32'h0000_0000;
        end
        if (wr && wb_sel_i[0] && wb_sel_i[1]) begin
            if (wb_adr_i == dplm_pkg::DPLM_OFS_BRAKE_LO) begin
                brake_lo_d = wb_dat_i[15:0];
            end else if (wb_adr_i == dplm_pkg::DPLM_OFS_BRAKE_HI) begin
                brake_hi_d = wb_dat_i[15:0];
            end else if (wb_adr_i == dplm_pkg::DPLM_OFS_DUTY_MOT) begin
                duty_mot_d = wb_dat_i[15:0];
            end else if (wb_adr_i == dplm_pkg::DPLM_OFS_DUTY_GEN) begin
                duty_gen_d = wb_dat_i[15:0];
            end else if (wb_adr_i == dplm_pkg::DPLM_OFS_CUR_OFS) begin
                cur_ofs_d = wb_dat_i[15:0];
            end else if (wb_adr_i == dplm_pkg::DPLM_OFS_OC_ALLOW) begin
                oc_allow_d = wb_dat_i[15:0];
            end
        end
        ack_d = req && hit;
        err_d = req && !hit;
    end

    // ---------------------------------------------
    // state registers
    // ---------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            brake_lo_q <= dplm_pkg::DPLM_RST_BRAKE_LO;
            brake_hi_q <= dplm_pkg::DPLM_RST_BRAKE_HI;
            duty_mot_q <= dplm_pkg::DPLM_RST_DUTY;
            duty_gen_q <= dplm_pkg::DPLM_RST_DUTY;
            cur_ofs_q  <= dplm_pkg::DPLM_RST_CUR_OFS;
            oc_allow_q <= dplm_pkg::DPLM_RST_OC_ALLOW;
            cause_q    <= 16'h0000;
            oc_cnt_q   <= 16'h0000;
            gen_act_q  <= 16'h0000;
            duty_q     <= 16'h0000;
            brk_ceil_q <= 16'h0000;
            lamp_q     <= 1'b0;
            en_prev_q  <= 1'b0;
            rdat_q     <= 32'h0000_0000;
            ack_q      <= 1'b0;
            err_q      <= 1'b0;
            fcode_q    <= 16'h0000;
            fact_q     <= 1'b0;
            fst_q      <= dplm_pkg::DPLM_RUN;
        end else begin
            brake_lo_q <= brake_lo_d;
            brake_hi_q <= brake_hi_d;
            duty_mot_q <= duty_mot_d;
            duty_gen_q <= duty_gen_d;
            cur_ofs_q  <= cur_ofs_d;
            oc_allow_q <= oc_allow_d;
            cause_q    <= cause_d;
            oc_cnt_q   <= oc_cnt_d;
            gen_act_q  <= gen_act_d;
            duty_q     <= duty_d;
            brk_ceil_q <= brk_ceil_d;
            lamp_q     <= lamp_d;
            en_prev_q  <= en_prev_d;
            rdat_q     <= rdat_d;
            ack_q      <= ack_d;
            err_q      <= err_d;
            fcode_q    <= fcode_d;
            fact_q     <= fact_d;
            fst_q      <= fst_d;
        end
    end

    assign wb_dat_o                = rdat_q;
    assign wb_ack_o                = ack_q;
    assign wb_err_o                = err_q;
    assign duty_out                = duty_q;
    assign braking_current_ceiling = brk_ceil_q;
    assign limit_lamp              = lamp_q;
    assign fault_active            = fact_q;
    assign fault_code              = fcode_q;

    // ---------------------------------------------
    // assertions
    // ---------------------------------------------
    a_ceiling_zero_top: assert property (@(posedge clock) disable iff (sys_rst)
        bridge_i.braking && bridge_i.dc_link_mv >= brake_hi_q |=> gen_act_q == 16'h0000)
        else $error("generator ceiling not zero at upper threshold");
    a_ceiling_full_low: assert property (@(posedge clock) disable iff (sys_rst)
        bridge_i.dc_link_mv <= brake_lo_q |=> gen_act_q == $past(duty_gen_q))
        else $error("ceiling reduced below lower threshold");
    a_no_reduce_idle: assert property (@(posedge clock) disable iff (sys_rst)
        !bridge_i.braking |=> gen_act_q == $past(duty_gen_q))
        else $error("ceiling reduced while not braking");
    a_overvolt_bit: assert property (@(posedge clock) disable iff (sys_rst)
        bridge_i.braking && bridge_i.gen_mode && bridge_i.dc_link_mv > brake_lo_q |=> cause_q[2])
        else $error("over-voltage cause bit missing");
    a_cause_sticky: assert property (@(posedge clock) disable iff (sys_rst)
        cause_q[7] && !en_rise && !(wr && wb_adr_i == dplm_pkg::DPLM_OFS_CAUSE) |=> cause_q[7])
        else $error("cause bit dropped without clear");
    a_cause_clear_en: assert property (@(posedge clock) disable iff (sys_rst)
        en_rise && lim_set == 16'h0000 |=> cause_q == 16'h0000)
        else $error("cause mask not cleared on enable");
    a_ctrl_bit: assert property (@(posedge clock) disable iff (sys_rst)
        bridge_i.ctrl_limiting |=> cause_q[3] && limit_lamp)
        else $error("controller limit not flagged");
    a_lamp_follow: assert property (@(posedge clock) disable iff (sys_rst)
        (bridge_i.mot_pos_lim || bridge_i.gen_neg_lim) |=> limit_lamp && (cause_q[4] || cause_q[7]))
        else $error("lamp or current bit missing");
    a_fault_code: assert property (@(posedge clock) disable iff (sys_rst)
        fst_q == dplm_pkg::DPLM_RUN && bridge_i.oc_pos_evt && oc_cnt_q >= oc_allow_q && !en_rise
        |=> fault_code == 16'h2221)
        else $error("positive over-current fault not raised");
    a_counter_restart: assert property (@(posedge clock) disable iff (sys_rst)
        en_rise |=> oc_cnt_q == 16'h0000 && !fault_active)
        else $error("counter not restarted on enable");
    a_brake_ceiling: assert property (@(posedge clock) disable iff (sys_rst)
        ##1 braking_current_ceiling == $past(cur_ofs_q))
        else $error("braking current ceiling not offset");
    c_overvolt: cover property (@(posedge clock) bridge_i.braking && ovolt && !gen_act_q[15]);
    c_fault_neg: cover property (@(posedge clock) fst_q == dplm_pkg::DPLM_FAULT_N);
    c_cause_write: cover property (@(posedge clock) wr && wb_adr_i == dplm_pkg::DPLM_OFS_CAUSE);

endmodule

`default_nettype wire

// ==== dplm_pkg.sv ====
// Purpose: shared constants and types of the drive power limit monitor
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes:   register offsets below are word aligned
package dplm_pkg;

    // ---------------------------------------------
    // register offsets
    // ---------------------------------------------
    localparam logic [7:0] DPLM_OFS_BRAKE_LO  = 8'h00;
    localparam logic [7:0] DPLM_OFS_BRAKE_HI  = 8'h04;
    localparam logic [7:0] DPLM_OFS_DUTY_MOT  = 8'h08;
    localparam logic [7:0] DPLM_OFS_DUTY_GEN  = 8'h0C;
    localparam logic [7:0] DPLM_OFS_DUTY_ACT  = 8'h10;
    localparam logic [7:0] DPLM_OFS_CUR_OFS   = 8'h14;
    localparam logic [7:0] DPLM_OFS_OC_ALLOW  = 8'h18;
    localparam logic [7:0] DPLM_OFS_CAUSE     = 8'h1C;
    localparam logic [7:0] DPLM_OFS_FAULT     = 8'h20;

    // ---------------------------------------------
    // reset values and field positions
    // ---------------------------------------------
    localparam logic [15:0] DPLM_RST_BRAKE_LO = 16'h0000;
    localparam logic [15:0] DPLM_RST_BRAKE_HI = 16'hFFFF;
    localparam logic [15:0] DPLM_RST_DUTY     = 16'h0000;
    localparam logic [15:0] DPLM_RST_CUR_OFS  = 16'h0000;
    localparam logic [15:0] DPLM_RST_OC_ALLOW = 16'h0000;
    localparam logic [15:0] DPLM_FAULT_POS    = 16'h2221;
    localparam logic [15:0] DPLM_FAULT_NEG    = 16'h2222;
    localparam int          DPLM_BIT_MOT_DUTY = 0;
    localparam int          DPLM_BIT_GEN_DUTY = 1;
    localparam int          DPLM_BIT_OVERVOLT = 2;
    localparam int          DPLM_BIT_CTRL_LIM = 3;
    localparam int          DPLM_BIT_MOT_POS  = 4;
    localparam int          DPLM_BIT_MOT_NEG  = 5;
    localparam int          DPLM_BIT_GEN_POS  = 6;
    localparam int          DPLM_BIT_GEN_NEG  = 7;

    // ---------------------------------------------
    // types
    // ---------------------------------------------
    typedef struct packed {
        logic        braking;
        logic        drive_enable;
        logic [15:0] dc_link_mv;
        logic [15:0] duty_cmd;
        logic        gen_mode;
        logic        ctrl_limiting;
        logic        mot_pos_lim;
        logic        mot_neg_lim;
        logic        gen_pos_lim;
        logic        gen_neg_lim;
        logic        oc_pos_evt;
        logic        oc_neg_evt;
    } dplm_bridge_t;

    typedef enum logic [1:0] {
        DPLM_RUN      = 2'b00,
        DPLM_FAULT_P  = 2'b01,
        DPLM_FAULT_N  = 2'b10
    } dplm_fault_state_t;

endpackage

// ==== tb_top.sv ====
// Purpose: self-checking bench of the power limit monitor
// Assumes: monitor acks one cycle after taking a request
// Notes:   random values from a fixed-seed xorshift
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ------------------------------
    // signals
    // ------------------------------
    logic                   clock;
    logic                   sys_rst;
    logic                   cyc;
    logic                   stb;
    logic                   we;
    logic [7:0]             adr;
    logic [3:0]             sel;
    logic [31:0]            dat;
    logic [31:0]            dat_o;
    logic                   ack;
    logic                   err;
    dplm_pkg::dplm_bridge_t want;
    dplm_pkg::dplm_bridge_t bridge;
    logic [15:0]            duty_out;
    logic [15:0]            brk_ceil;
    logic                   lamp;
    logic [15:0]            fault_code;
    logic                   fault_active;
    int                     fail_count;
    int                     check_count;
    int                     cycles;
    logic [31:0]            rs;
    logic [31:0]            rd;
    logic                   re;
    int                     vtab [4] = '{1000, 1001, 1999, 2000};

    dplm_bridge_model partner (.clock(clock), .sys_rst(sys_rst), .want_i(want), .bridge_o(bridge));
    dplm_monitor dut (
        .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .wb_err_o(err), .bridge_i(bridge), .duty_out(duty_out), .braking_current_ceiling(brk_ceil),
        .limit_lamp(lamp), .fault_code(fault_code), .fault_active(fault_active));

    // ------------------------------
    // helpers
    // ------------------------------
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction

    function automatic logic [15:0] exp_ceil(input logic [15:0] lo, hi, dg, v);
        if (v <= lo) return dg;
        if (v >= hi) return 16'h0000;
        return 16'((32'(dg) * 32'(hi - v)) / 32'(hi - lo));
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do begin
            @(posedge clock);
        end while (ack !== 1'b1 && err !== 1'b1);
        rd = dat_o;
        re = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hF);
    endtask

    task automatic rdck(input string name, input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h00000000, 4'hF);
        chk(name, rd, exp);
    endtask

    task automatic settle();
        repeat (3) @(posedge clock);
    endtask

    task automatic reenable();
        want.drive_enable <= 1'b0;
        settle();
        want.drive_enable <= 1'b1;
        settle();
    endtask

    task automatic set_cause(input int b, input logic on);
        case (b)
            3: want.ctrl_limiting <= on;
            4: want.mot_pos_lim <= on;
            5: want.mot_neg_lim <= on;
            6: want.gen_pos_lim <= on;
            default: want.gen_neg_lim <= on;
        endcase
    endtask

    // ------------------------------
    // clock and timeout
    // ------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end

    // ------------------------------
    // scenarios
    // ------------------------------
    initial begin
        int v;
        int n;
        int sticky;
        logic [15:0] dg;
        logic [15:0] ofs;
        logic [15:0] exp;
        sys_rst = 1'b1;
        {cyc, stb, we, adr, sel, dat} = '0;
        want = '0;
        fail_count = 0;
        check_count = 0;
        cycles = 0;
        rs = 32'h4C7BE494;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            rdck("reset value", 8'(i * 4), (i == 1) ? 32'h0000FFFF : 32'h00000000);
        end
        wb(1'b0, 8'h24, 32'h00000000, 4'hF);
        chk("unmapped err", re, 1'b1);
        wr(8'h10, 32'h00001234);
        rdck("read-only ceiling", 8'h10, 32'h00000000);
        ofs = 16'(xs());
        wr(8'h14, 32'(ofs));
        settle();
        chk("braking current ceiling", brk_ceil, ofs);
        wb(1'b1, 8'h14, 32'(~ofs), 4'hC);
        rdck("partial write", 8'h14, ofs);
        want.drive_enable <= 1'b1;
        wr(8'h00, 32'h000003E8);
        wr(8'h04, 32'h000007D0);
        dg = 16'(xs()) | 16'h8000;
        wr(8'h0C, 32'(dg));
        sticky = 0;
        for (int i = 0; i < 12; i++) begin
            v = (i < 4) ? vtab[i] : 800 + int'(xs() % 1400);
            want.braking <= 1'b1;
            want.gen_mode <= 1'b1;
            want.dc_link_mv <= 16'(v);
            want.duty_cmd <= 16'hFFFF;
            settle();
            exp = exp_ceil(16'h03E8, 16'h07D0, dg, 16'(v));
            chk("braking duty out", duty_out, exp);
            rdck("active ceiling", 8'h10, exp);
            sticky = sticky | int'(v > 1000);
            wb(1'b0, 8'h1C, 32'h00000000, 4'hF);
            chk("overvoltage bit", rd[2], sticky);
        end
        want.braking <= 1'b0;
        want.gen_mode <= 1'b0;
        want.duty_cmd <= 16'h0000;
        want.dc_link_mv <= 16'h0000;
        settle();
        wr(8'h1C, 32'h00000000);
        rdck("mask cleared by write", 8'h1C, 32'h00000000);
        for (int b = 3; b < 8; b++) begin
            set_cause(b, 1'b1);
            settle();
            chk("lamp on", lamp, 1'b1);
            set_cause(b, 1'b0);
            settle();
            chk("lamp off", lamp, 1'b0);
            rdck("sticky mask", 8'h1C, 32'((1 << (b + 1)) - 8));
        end
        wr(8'h08, 32'h00000100);
        wr(8'h0C, 32'h00000100);
        want.duty_cmd <= 16'h0200;
        settle();
        chk("motor clamp", duty_out, 16'h0100);
        want.gen_mode <= 1'b1;
        settle();
        chk("generator clamp", duty_out, 16'h0100);
        rdck("duty bits", 8'h1C, 32'h000000FB);
        want.duty_cmd <= 16'h0000;
        want.gen_mode <= 1'b0;
        reenable();
        rdck("mask cleared by enable", 8'h1C, 32'h00000000);
        for (int p = 0; p < 2; p++) begin
            n = 1 + int'(xs() % 4);
            wr(8'h18, 32'(n));
            for (int k = 0; k <= n; k++) begin
                want.oc_pos_evt <= (p == 0);
                want.oc_neg_evt <= (p == 1);
                @(posedge clock);
                want.oc_pos_evt <= 1'b0;
                want.oc_neg_evt <= 1'b0;
                settle();
                chk("fault active", fault_active, k == n);
            end
            exp = p ? dplm_pkg::DPLM_FAULT_NEG : dplm_pkg::DPLM_FAULT_POS;
            chk("fault code", fault_code, exp);
            rdck("fault word", 8'h20, {15'h0000, 1'b1, exp});
            reenable();
            chk("fault cleared", fault_active, 1'b0);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
